/* File: verilog/lcsr_cell.v */
// Logic cell storage: two storage elements, two RAM lookup tables, combining table
//
// Functional notes
// - Two D storage elements share one clock input and one enable.
// - Each element captures on rising or falling edge, chosen per element.
// - Clock inversion is selected separately for each element.
// - hold_gate is active high; one lets an element update.
// - An element whose hold_gate is unused is always enabled.
// - hold_gate has no inversion; its sense is fixed high.
// - hold_gate low and preset_clear_line low keeps the stored value.
// - Elements may act as transparent latches in the extended variant.
// - Latch follows data while trigger is low, holds while high.
// - Flip-flop takes data at the active trigger edge, else holds.
// - Global init or preset_clear_line force the set/reset value; reset loads zero.
// - Forced value is configurable set or reset; reset is default.
// - Lookup tables can be RAM written on a clock edge.
// - Edge write leaves the read path combinational.
// - An option makes the pair one dual-port RAM, one bit wide.
// - Tables are level RAM, edge RAM, dual-port RAM or logic.
// - RAM contents are loaded at configuration time.
// - Combining table takes both table outputs and control inputs.
// - The RAM write timing mode applies to both tables jointly.
//
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/10ps

`include "lcsr_map.vh"

module lcsr_cell #(
   parameter HAS_LATCH = 1,
   parameter AW        = 4
)(
   // Clock, reset, enable
   input  wire          clk,
   input  wire          nrst,
   input  wire          ce,
   // AHB-Lite slave
   input  wire          hsel,
   input  wire [31:0]   haddr,
   input  wire [1:0]    htrans,
   input  wire          hwrite,
   input  wire [2:0]    hsize,
   input  wire [31:0]   hwdata,
   input  wire          hready,
   output wire          hreadyout,
   output wire          hresp,
   output wire [31:0]   hrdata,
   // Storage element inputs
   input  wire          storageTrigger,
   input  wire          holdGate,
   input  wire          presetClearLine,
   input  wire          globalInitPulse,
   input  wire [1:0]    inputBit,
   // Lookup table inputs
   input  wire [AW-1:0] addrF,
   input  wire [AW-1:0] addrG,
   input  wire [1:0]    ramDin,
   input  wire          ramWe,
   input  wire [3:0]    ctlIn,
   // Cell outputs
   output wire [1:0]    storedOut,
   output wire          lutFOut,
   output wire          lutGOut,
   output wire          hOut
);

   localparam DEPTH = 1 << AW;

   // Bus state
   reg          wrPend_reg;
   reg          rdPend_reg;
   reg  [7:0]   addr_reg;
   reg          addrHit_reg;
   reg          hreadyout_reg;
   reg          hresp_reg;
   reg  [31:0]  hrdata_reg;
   reg  [31:0]  rdMux;

   // Configuration
   reg  [31:0]  ctrl_reg;
   reg  [7:0]   htab_reg;
   reg  [1:0]   lutLoad;

   // Cell state
   reg          trigPrev_reg;
   reg  [1:0]   q_reg;
   reg          lutFOut_reg;
   reg          lutGOut_reg;
   reg          hOut_reg;

   // Decoded control fields
   wire [1:0]   clkInv;
   wire         latchMode;
   wire [1:0]   ecUse;
   wire [1:0]   srVal;
   wire         ramInv;
   wire [1:0]   lutMode;
   wire [2:0]   hSel0;
   wire [2:0]   hSel1;
   wire [2:0]   hSel2;

   // Lookup table wiring
   wire [1:0]       lutWrEn;
   wire [AW-1:0]    lutWrAddr [0:1];
   wire [1:0]       lutWrData;
   wire [AW-1:0]    lutRdAddr [0:1];
   wire [1:0]       lutRd;
   wire [DEPTH-1:0] lutBits [0:1];

   // Trigger edge and RAM write qualification
   wire         ramTrig;
   wire         ramTrigPrev;
   wire         ramEdge;
   wire         ramWrite;
   wire         dualPort;
   wire         ramUsed;
   wire         forceVal;
   wire         busAcc;
   wire [2:0]   hIdx;

   // Field extraction from the control register
   assign clkInv    = ctrl_reg[`LCSR_B_INV +: 2];
   assign latchMode = (HAS_LATCH != 0) & ctrl_reg[`LCSR_B_LATCH];
   assign ecUse     = ctrl_reg[`LCSR_B_ECUSE +: 2];
   assign srVal     = ctrl_reg[`LCSR_B_SRVAL +: 2];
   assign ramInv    = ctrl_reg[`LCSR_B_RAMINV];
   assign lutMode   = ctrl_reg[`LCSR_B_MODE +: 2];
   assign hSel0     = ctrl_reg[`LCSR_B_HSEL +: 3];
   assign hSel1     = ctrl_reg[(`LCSR_B_HSEL + `LCSR_HSEL_STEP) +: 3];
   assign hSel2     = ctrl_reg[(`LCSR_B_HSEL + 2 * `LCSR_HSEL_STEP) +: 3];

   // Bus request accepted in its address phase
   assign busAcc = hsel & hready & htrans[1];

   // AHB-Lite slave: writes zero wait, reads one wait state
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wrPend_reg    <= 1'b0;
         rdPend_reg    <= 1'b0;
         addr_reg      <= 8'h00;
         addrHit_reg   <= 1'b0;
         hreadyout_reg <= 1'b1;
         hresp_reg     <= 1'b0;
         hrdata_reg    <= 32'h0000_0000;
      end
      else if (ce)
      begin
         wrPend_reg <= busAcc & hwrite;
         rdPend_reg <= busAcc & ~hwrite;
         if (busAcc)
         begin
            addr_reg    <= {haddr[7:2], 2'b00};
            addrHit_reg <= (haddr[31:8] == 24'h00_0000);
         end
         if (busAcc & ~hwrite)
         begin
            hreadyout_reg <= 1'b0;
         end
         else if (rdPend_reg)
         begin
            hreadyout_reg <= 1'b1;
            hrdata_reg    <= rdMux;
         end
      end
   end

   // Read data selection; unmapped words read zero
   always @*
   begin
      rdMux = 32'h0000_0000;
      if (addrHit_reg)
      begin
         case (addr_reg)
            `LCSR_A_CTRL: rdMux = ctrl_reg;
            `LCSR_A_LUTF: rdMux = {{(32-DEPTH){1'b0}}, lutBits[0]};
            `LCSR_A_LUTG: rdMux = {{(32-DEPTH){1'b0}}, lutBits[1]};
            `LCSR_A_HTAB: rdMux = {24'h00_0000, htab_reg};
            `LCSR_A_STAT: rdMux = {27'h000_0000, hOut_reg, lutGOut_reg,
                                   lutFOut_reg, q_reg};
            default:      rdMux = 32'h0000_0000;
         endcase
      end
   end

   // Configuration register writes in the data phase
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl_reg <= `LCSR_CTRL_RST;
         htab_reg <= `LCSR_HTAB_RST;
      end
      else if (ce & wrPend_reg & addrHit_reg)
      begin
         case (addr_reg)
            `LCSR_A_CTRL: ctrl_reg <= hwdata & `LCSR_CTRL_MASK;
            `LCSR_A_HTAB: htab_reg <= hwdata[7:0];
            default:      ctrl_reg <= ctrl_reg;
         endcase
      end
   end

   // Table preload strobes from a write to either table word
   always @*
   begin
      lutLoad = 2'b00;
      if (wrPend_reg & addrHit_reg)
      begin
         lutLoad[0] = (addr_reg == `LCSR_A_LUTF);
         lutLoad[1] = (addr_reg == `LCSR_A_LUTG);
      end
   end

   // Previous trigger sample for edge detection
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         trigPrev_reg <= 1'b0;
      end
      else if (ce)
      begin
         trigPrev_reg <= storageTrigger;
      end
   end

   // Set/reset dominates clock, enable and data
   assign forceVal = globalInitPulse | presetClearLine;

   // Two storage elements on the shared trigger and shared hold_gate
   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1)
      begin : gElem
         wire effTrig;
         wire effPrev;
         wire elemEn;

         assign effTrig = storageTrigger ^ clkInv[i];
         assign effPrev = trigPrev_reg ^ clkInv[i];
         assign elemEn  = holdGate | ~ecUse[i];

         always @(posedge clk or negedge nrst)
         begin
            if (!nrst)
            begin
               q_reg[i] <= 1'b0;
            end
            else if (ce)
            begin
               if (forceVal)
               begin
                  q_reg[i] <= srVal[i];
               end
               else if (elemEn)
               begin
                  if (latchMode)
                  begin
                     if (!effTrig)
                     begin
                        q_reg[i] <= inputBit[i];
                     end
                  end
                  else if (effTrig & ~effPrev)
                  begin
                     q_reg[i] <= inputBit[i];
                  end
               end
            end
         end
      end
   endgenerate

   // RAM write timing shared by both tables
   assign ramTrig     = storageTrigger ^ ramInv;
   assign ramTrigPrev = trigPrev_reg ^ ramInv;
   assign ramEdge     = ramTrig & ~ramTrigPrev;
   assign dualPort    = (lutMode == `LCSR_M_DUAL);
   assign ramUsed     = (lutMode != `LCSR_M_LOGIC);
   assign ramWrite    = (lutMode == `LCSR_M_LEVEL) ? ramWe
                                                   : (ramWe & ramEdge);

   // Single port: own address and data; dual port: shared write port
   assign lutWrEn      = {2{ramUsed & ramWrite}};
   assign lutWrAddr[0] = addrF;
   assign lutWrAddr[1] = dualPort ? addrF : addrG;
   assign lutWrData[0] = ramDin[0];
   assign lutWrData[1] = dualPort ? ramDin[0] : ramDin[1];
   assign lutRdAddr[0] = addrF;
   assign lutRdAddr[1] = addrG;

   // The two main lookup tables
   genvar k;
   generate
      for (k = 0; k < 2; k = k + 1)
      begin : gLut
         lcsr_lut #(
            .AW       (AW)
         ) uLut (
            .clk      (clk),
            .nrst     (nrst),
            .ce       (ce),
            .loadEn   (lutLoad[k]),
            .loadData (hwdata[DEPTH-1:0]),
            .wrEn     (lutWrEn[k]),
            .wrAddr   (lutWrAddr[k]),
            .wrData   (lutWrData[k]),
            .rdAddr   (lutRdAddr[k]),
            .rdData   (lutRd[k]),
            .contents (lutBits[k])
         );
      end
   endgenerate

   // Combining table input source: F, G, one control input or constant zero
   function hSrc;
      input [2:0] sel;
      input       f;
      input       g;
      input [3:0] c;
      begin
         case (sel)
            3'h0:    hSrc = f;
            3'h1:    hSrc = g;
            3'h2:    hSrc = c[0];
            3'h3:    hSrc = c[1];
            3'h4:    hSrc = c[2];
            3'h5:    hSrc = c[3];
            default: hSrc = 1'b0;
         endcase
      end
   endfunction

   // Three combining inputs form the truth table index
   assign hIdx = {hSrc(hSel2, lutRd[0], lutRd[1], ctlIn),
                  hSrc(hSel1, lutRd[0], lutRd[1], ctlIn),
                  hSrc(hSel0, lutRd[0], lutRd[1], ctlIn)};

   // Registered table outputs
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         lutFOut_reg <= 1'b0;
         lutGOut_reg <= 1'b0;
         hOut_reg    <= 1'b0;
      end
      else if (ce)
      begin
         lutFOut_reg <= lutRd[0];
         lutGOut_reg <= lutRd[1];
         hOut_reg    <= htab_reg[hIdx];
      end
   end

   // Output drive
   assign storedOut = q_reg;
   assign lutFOut   = lutFOut_reg;
   assign lutGOut   = lutGOut_reg;
   assign hOut      = hOut_reg;
   assign hreadyout = hreadyout_reg;
   assign hresp     = hresp_reg;
   assign hrdata    = hrdata_reg;

endmodule

/* File: shared/lcsr_map.vh */
// Register offsets, field positions and reset values of the logic cell
`ifndef LCSR_MAP_VH
`define LCSR_MAP_VH

// Register byte offsets
`define LCSR_A_CTRL   8'h00
`define LCSR_A_LUTF   8'h04
`define LCSR_A_LUTG   8'h08
`define LCSR_A_HTAB   8'h0c
`define LCSR_A_STAT   8'h10

// Control field positions
`define LCSR_B_INV    0
`define LCSR_B_LATCH  2
`define LCSR_B_ECUSE  3
`define LCSR_B_SRVAL  5
`define LCSR_B_RAMINV 7
`define LCSR_B_MODE   8
`define LCSR_B_HSEL   12
`define LCSR_HSEL_STEP 4

// Writable control bits
`define LCSR_CTRL_MASK 32'h0077_73ff

// Reset values
`define LCSR_CTRL_RST 32'h0000_0000
`define LCSR_HTAB_RST 8'h00

// Lookup table modes
`define LCSR_M_LOGIC  2'h0
`define LCSR_M_LEVEL  2'h1
`define LCSR_M_EDGE   2'h2
`define LCSR_M_DUAL   2'h3

`endif

/* File: verilog/lcsr_lut.v */
// One sixteen-entry lookup table usable as truth table or as RAM
`timescale 1ns/10ps

module lcsr_lut #(
   parameter AW = 4
)(
   // Clock, reset, enable
   input  wire                clk,
   input  wire                nrst,
   input  wire                ce,
   // Configuration load
   input  wire                loadEn,
   input  wire [(1<<AW)-1:0]  loadData,
   // Write port
   input  wire                wrEn,
   input  wire [AW-1:0]       wrAddr,
   input  wire                wrData,
   // Read port
   input  wire [AW-1:0]       rdAddr,
   output wire                rdData,
   output wire [(1<<AW)-1:0]  contents
);

   localparam DEPTH = 1 << AW;

   reg [DEPTH-1:0] mem_reg;

   // Whole-table preload wins over a user write in the same cycle
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mem_reg <= {DEPTH{1'b0}};
      end
      else if (ce)
      begin
         if (loadEn)
         begin
            mem_reg <= loadData;
         end
         else if (wrEn)
         begin
            mem_reg[wrAddr] <= wrData;
         end
      end
   end

   // Read is purely combinational from address
   assign rdData   = mem_reg[rdAddr];
   assign contents = mem_reg;

endmodule

/* File: verif/lcsr_user.sv */
// Surrounding user logic model that drives the cell clock through routing
`timescale 1ns/10ps

module lcsr_user (
   // Clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // Level asked for by the sequencer
   input  wire logic trigWant,
   // Routed cell clock
   output logic      storageTrigger
);
   // One register stage stands for the routing delay
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         storageTrigger <= 1'h0;
      else
         storageTrigger <= trigWant;
   end
endmodule

/* File: verif/lcsr_cell_chk.sv */
// Assertion checker for the logic cell storage block
`timescale 1ns/10ps
`include "lcsr_map.vh"

module lcsr_cell_chk (
   // Clock, reset, enable
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        ce,
   // Bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Storage elements
   input wire logic        storageTrigger,
   input wire logic        holdGate,
   input wire logic        presetClearLine,
   input wire logic        globalInitPulse,
   input wire logic [1:0]  inputBit,
   input wire logic [1:0]  storedOut
);
   logic        wrPend;
   logic [31:0] ctrlS;
   wire         frc  = presetClearLine | globalInitPulse;
   wire         en0  = holdGate | ~ctrlS[3];
   wire         en1  = holdGate | ~ctrlS[4];
   wire         act0 = storageTrigger ^ ctrlS[0];
   wire         act1 = storageTrigger ^ ctrlS[1];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // Shadow of the control word, taken from bus writes
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wrPend <= 1'h0;
         ctrlS  <= 32'h0;
      end
      else if (ce && hready)
      begin
         wrPend <= hsel & htrans[1] & hwrite & (haddr == 32'h0);
         if (wrPend)
            ctrlS <= hwdata & `LCSR_CTRL_MASK;
      end
   end

   // Storage element behaviour
   force_out_a:
      assert property (ce && frc |=> storedOut == $past(ctrlS[6:5]))
      else $error("forced value wrong");
   hold_low_a:
      assert property (ce && !frc && !holdGate && ctrlS[3] && ctrlS[4] |=> $stable(storedOut))
      else $error("disabled element changed");
   ff_edge0_a:
      assert property (ce && !frc && !ctrlS[2] && en0 && act0 &&
         !($past(storageTrigger) ^ ctrlS[0]) |=> storedOut[0] == $past(inputBit[0]))
      else $error("element 0 missed edge");
   ff_edge1_a:
      assert property (ce && !frc && !ctrlS[2] && en1 && act1 &&
         !($past(storageTrigger) ^ ctrlS[1]) |=> storedOut[1] == $past(inputBit[1]))
      else $error("element 1 missed edge");
   latch_follow_a:
      assert property (ce && !frc && ctrlS[2] && en0 && !act0 |=>
         storedOut[0] == $past(inputBit[0]))
      else $error("latch not transparent");
   latch_hold_a:
      assert property (ce && !frc && ctrlS[2] && act0 |=> $stable(storedOut[0]))
      else $error("latch not holding");
   // Bus behaviour
   read_wait_a:
      assert property (ce && hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   resp_okay_a:
      assert property (hresp == 1'h0)
      else $error("response not okay");
endmodule

bind lcsr_cell lcsr_cell_chk i_lcsr_cell_chk (
   .clk(clk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .storageTrigger(storageTrigger), .holdGate(holdGate),
   .presetClearLine(presetClearLine), .globalInitPulse(globalInitPulse),
   .inputBit(inputBit), .storedOut(storedOut)
);

/* File: verif/lcsr_cell_test.sv */
// Self-checking bench for the logic cell storage block
`timescale 1ns/10ps
`include "lcsr_map.vh"

module lcsr_cell_test;
   logic        clk = '0, nrst = '0, hsel = '0, hwrite = '0, trigWant = '0, ramWe = '0;
   logic        holdGate = '0, presetClearLine = '0, globalInitPulse = '0, ce = '1;
   logic [1:0]  htrans = '0, inputBit = '0, ramDin = '0;
   logic [31:0] haddr = '0, hwdata = '0, rdv;
   logic [3:0]  addrF = '0, addrG = '0, ctlIn = '0;
   wire         hreadyout, hresp, storageTrigger, lutFOut, lutGOut, hOut;
   wire  [31:0] hrdata;
   wire  [1:0]  storedOut;
   int          mismatches = 0, checkCount = 0, cycles = 0;

   // Clock and run ceiling
   always #2.5 clk = ~clk;
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         mismatches++;
         wrapUp();
      end
   end

   // Far side and device
   lcsr_user i_lcsr_user (.clk(clk), .nrst(nrst), .trigWant(trigWant),
      .storageTrigger(storageTrigger));
   lcsr_cell i_lcsr_cell (.clk(clk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .storageTrigger(storageTrigger),
      .holdGate(holdGate), .presetClearLine(presetClearLine), .globalInitPulse(globalInitPulse),
      .inputBit(inputBit), .addrF(addrF), .addrG(addrG), .ramDin(ramDin), .ramWe(ramWe),
      .ctlIn(ctlIn), .storedOut(storedOut), .lutFOut(lutFOut), .lutGOut(lutGOut), .hOut(hOut));

   task automatic wrapUp();
      $display("checks %0d mismatches %0d", checkCount, mismatches);
      if (mismatches == 0 && checkCount > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      checkCount++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   // Single AHB transfer; returns at the edge that ends the data phase
   task automatic ahb(logic w, logic [31:0] a, logic [31:0] d);
      @(posedge clk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'h1);
      rdv = hrdata;
   endtask

   task automatic rd(logic [31:0] a, logic [31:0] e, string n);
      ahb(1'h0, a, 32'h0);
      chk(n, e, rdv);
   endtask

   task automatic pulse(logic w);
      @(posedge clk);
      trigWant <= w;
      cyc(3);
   endtask

   task automatic regT();
      rd(`LCSR_A_CTRL, 32'h0, "ctrl rst");
      rd(`LCSR_A_STAT, 32'h0, "stat rst");
      ahb(1'h1, `LCSR_A_CTRL, 32'hffff_ffff);
      rd(`LCSR_A_CTRL, 32'h0077_73ff, "ctrl mask");
      rd(32'h14, 32'h0, "unmapped");
   endtask

   task automatic ffT();
      ahb(1'h1, `LCSR_A_CTRL, 32'h0);
      inputBit <= 2'h3;
      pulse(1'h1);
      pulse(1'h0);
      chk("ff", 32'h3, storedOut);
      ahb(1'h1, `LCSR_A_CTRL, 32'h18);
      inputBit <= 2'h0;
      pulse(1'h1);
      pulse(1'h0);
      chk("hold", 32'h3, storedOut);
      @(posedge clk);
      holdGate <= 1'h1;
      pulse(1'h1);
      pulse(1'h0);
      chk("enable", 32'h0, storedOut);
      ahb(1'h1, `LCSR_A_CTRL, 32'h19);
      cyc(2);
      @(posedge clk);
      inputBit <= 2'h3;
      pulse(1'h1);
      chk("inv rise", 32'h2, storedOut);
      pulse(1'h0);
      chk("inv fall", 32'h3, storedOut);
   endtask

   task automatic forceT();
      ahb(1'h1, `LCSR_A_CTRL, 32'h0);
      globalInitPulse <= 1'h1;
      cyc(2);
      chk("init", 32'h0, storedOut);
      @(posedge clk);
      globalInitPulse <= 1'h0;
      ahb(1'h1, `LCSR_A_CTRL, 32'h60);
      presetClearLine <= 1'h1;
      inputBit <= 2'h0;
      pulse(1'h1);
      chk("preset", 32'h3, storedOut);
      @(posedge clk);
      presetClearLine <= 1'h0;
      pulse(1'h0);
      // Clock enable low: a trigger edge must not reach the elements
      @(posedge clk);
      ce <= 1'h0;
      pulse(1'h1);
      chk("freeze", 32'h3, storedOut);
      @(posedge clk);
      ce <= 1'h1;
      pulse(1'h0);
   endtask

   task automatic latchT();
      ahb(1'h1, `LCSR_A_CTRL, 32'h04);
      inputBit <= 2'h1;
      cyc(2);
      chk("latch a", 32'h1, storedOut);
      @(posedge clk);
      inputBit <= 2'h2;
      cyc(2);
      chk("latch b", 32'h2, storedOut);
      pulse(1'h1);
      @(posedge clk);
      inputBit <= 2'h1;
      cyc(2);
      chk("latch hold", 32'h2, storedOut);
      pulse(1'h0);
      chk("latch open", 32'h1, storedOut);
   endtask

   task automatic ramT();
      ahb(1'h1, `LCSR_A_LUTF, 32'h8000);
      ahb(1'h1, `LCSR_A_CTRL, 32'h200);
      addrF <= 4'h5;
      ramDin <= 2'h1;
      ramWe <= 1'h1;
      pulse(1'h1);
      pulse(1'h0);
      @(posedge clk);
      ramWe <= 1'h0;
      rd(`LCSR_A_LUTF, 32'h8020, "edge ram");
      chk("f read", 32'h1, lutFOut);
      addrF <= 4'h6;
      ramWe <= 1'h1;
      cyc(3);
      @(posedge clk);
      ramWe <= 1'h0;
      rd(`LCSR_A_LUTF, 32'h8020, "no edge");
      // Inverted RAM trigger: write on the falling edge only
      ahb(1'h1, `LCSR_A_CTRL, 32'h280);
      ramWe <= 1'h1;
      pulse(1'h1);
      rd(`LCSR_A_LUTF, 32'h8020, "ram inv rise");
      pulse(1'h0);
      @(posedge clk);
      ramWe <= 1'h0;
      rd(`LCSR_A_LUTF, 32'h8060, "ram inv fall");
      ahb(1'h1, `LCSR_A_CTRL, 32'h100);
      addrF <= 4'h1;
      addrG <= 4'h2;
      ramDin <= 2'h3;
      ramWe <= 1'h1;
      cyc(2);
      @(posedge clk);
      ramWe <= 1'h0;
      rd(`LCSR_A_LUTF, 32'h8062, "level f");
      rd(`LCSR_A_LUTG, 32'h0004, "level g");
      ahb(1'h1, `LCSR_A_CTRL, 32'h300);
      addrF <= 4'h3;
      addrG <= 4'h9;
      ramDin <= 2'h1;
      ramWe <= 1'h1;
      pulse(1'h1);
      pulse(1'h0);
      @(posedge clk);
      ramWe <= 1'h0;
      rd(`LCSR_A_LUTG, 32'h000c, "dual g");
      addrG <= 4'h3;
      cyc(2);
      chk("g read", 32'h1, lutGOut);
   endtask

   task automatic hT();
      ahb(1'h1, `LCSR_A_HTAB, 32'h02);
      ahb(1'h1, `LCSR_A_CTRL, 32'h0066_2000);
      ctlIn <= 4'h1;
      cyc(2);
      chk("h one", 32'h1, hOut);
      @(posedge clk);
      ctlIn <= 4'h0;
      cyc(2);
      chk("h zero", 32'h0, hOut);
      // Table sources: F holds one at address 3, G zero at address 0
      ahb(1'h1, `LCSR_A_CTRL, 32'h0066_0000);
      addrG <= 4'h0;
      cyc(2);
      chk("h from f", 32'h1, hOut);
      ahb(1'h1, `LCSR_A_CTRL, 32'h0066_1000);
      cyc(2);
      chk("h from g", 32'h0, hOut);
   endtask

   // Main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      nrst <= 1'h1;
      regT();
      ffT();
      forceT();
      latchT();
      ramT();
      hT();
      wrapUp();
   end
endmodule
